/* logic/ofc_top.v */
// Summary of operation
// - Each over-range flag rises when its channel sample exceeds the threshold.
// - An asserted flag stays high at least the programmed hold count.
// - Channel B flag works only on quad and dual variants.
// - Channel C and D flags exist only on the quad variant.
// - Select both low (pins, or register bits2:1 under override) or clock disabled: pin C carries flag C.
// - Select 1 gives reference copy on C, 2 half rate, 3 quarter.
// - Clocks on C and D only with synth enable high and enabled.
// - Pin C clock runs from reset with strap selection alone.
// - Any select pin high without register override: pin D carries undivided reference copy.
// - Divided clock on pin D only through register override.
// - Pin D carries a clock only while pin C carries one.
// - Select both low (pins, or register bits2:1 under override) or clock disabled: pin D carries flag D.
// - Power-down high stops reference output and clocks on C and D.
`timescale 1ns/1ps
`include "ofc_defs.vh"

module ofc_top #(
    parameter SAMPLE_W = 12,
    parameter HOLD_W = 8,
    parameter [1:0] VARIANT = `OFC_VAR_QUAD
) (
    input wire CLK,
    input wire ARST_N,
    input wire [SAMPLE_W-1:0] SAMPLE_A,
    input wire [SAMPLE_W-1:0] SAMPLE_B,
    input wire [SAMPLE_W-1:0] SAMPLE_C,
    input wire [SAMPLE_W-1:0] SAMPLE_D,
    input wire SYNTH_REF_CLK,
    input wire [1:0] CLKOUT_SELECT_PINS,
    input wire SYNTH_ENABLE_PIN,
    input wire POWERDOWN_PIN,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    output reg OVR_FLAG_A,
    output reg OVR_FLAG_B,
    output reg OVR_FLAG_OR_CLK_C,
    output reg OVR_FLAG_OR_CLK_D,
    output reg SYNTH_REFERENCE_OUTPUT
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    reg [1:0] sel_m_q;
    reg [1:0] sel_s_q;
    reg en_m_q;
    reg en_s_q;
    reg pd_m_q;
    reg pd_s_q;
    reg ref_m_q;
    reg ref_s_q;

    // Two stages on every select, enable, power-down and reference pin; first stage feeds only the second
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sel_m_q <= 2'h0;
            sel_s_q <= 2'h0;
            en_m_q <= 1'b0;
            en_s_q <= 1'b0;
            pd_m_q <= 1'b1;
            pd_s_q <= 1'b1;
            ref_m_q <= 1'b0;
            ref_s_q <= 1'b0;
        end else begin
            sel_m_q <= CLKOUT_SELECT_PINS;
            sel_s_q <= sel_m_q;
            en_m_q <= SYNTH_ENABLE_PIN;
            en_s_q <= en_m_q;
            pd_m_q <= POWERDOWN_PIN;
            pd_s_q <= pd_m_q;
            ref_m_q <= SYNTH_REF_CLK;
            ref_s_q <= ref_m_q;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [SAMPLE_W-1:0] thresh_q;
    reg [HOLD_W-1:0] hold_q;
    // Bit0 select override on, bits2:1 select, bit3 disable, bits5:4 D divider
    reg [5:0] clkctl_q;

    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            thresh_q <= `OFC_RST_THRESH;
            hold_q <= `OFC_RST_HOLD;
            clkctl_q <= `OFC_RST_CLKCTL;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `OFC_ADDR_THRESH: begin
                    thresh_q <= REG_WDATA[SAMPLE_W-1:0];
                end
                `OFC_ADDR_HOLD: begin
                    hold_q <= REG_WDATA[HOLD_W-1:0];
                end
                `OFC_ADDR_CLKCTL: begin
                    clkctl_q <= REG_WDATA[5:0];
                end
                default: begin
                    clkctl_q <= clkctl_q;
                end
            endcase
        end
    end

    // ****************************************************************
    // Clock output selection
    // ****************************************************************
    wire [1:0] sel_c;
    wire [1:0] ddiv;
    wire clk_allowed;
    wire c_clk_mode;
    wire d_clk_mode;

    assign sel_c = clkctl_q[`OFC_CLKCTL_OVR_EN] ? clkctl_q[`OFC_CLKCTL_SEL_HI:`OFC_CLKCTL_SEL_LO] : sel_s_q;
    assign clk_allowed = en_s_q && !pd_s_q && !clkctl_q[`OFC_CLKCTL_DIS];
    assign c_clk_mode = clk_allowed && (sel_c != `OFC_SEL_FLAG);
    assign d_clk_mode = c_clk_mode;
    // divider on D only by register
    assign ddiv = clkctl_q[`OFC_CLKCTL_OVR_EN] ? clkctl_q[`OFC_CLKCTL_DDIV_HI:`OFC_CLKCTL_DDIV_LO] : `OFC_SEL_DIV1;

    wire div2;
    wire div4;

    ofc_clk_div u_div (
        .clk(CLK),
        .arst_n(ARST_N),
        .run(clk_allowed),
        .ref_clk(ref_s_q),
        .div2_q(div2),
        .div4_q(div4)
    );

    // Picks reference, half or quarter for a select code
    function pick_clk;
        input [1:0] sel;
        input r;
        input d2;
        input d4;
        begin
            case (sel)
                `OFC_SEL_DIV2: begin
                    pick_clk = d2;
                end
                `OFC_SEL_DIV4: begin
                    pick_clk = d4;
                end
                default: begin
                    pick_clk = r;
                end
            endcase
        end
    endfunction

    // ****************************************************************
    // Over-range detectors
    // ****************************************************************
    wire quad;
    wire multi;
    wire fa;
    wire fb;
    wire fc;
    wire fd;

    assign multi = (VARIANT == `OFC_VAR_DUAL) || (VARIANT == `OFC_VAR_QUAD);
    // C and D on quad only
    assign quad = (VARIANT == `OFC_VAR_QUAD);

    // Channel A exists on every variant
    ofc_ovr_det #(
        .SAMPLE_W(SAMPLE_W),
        .HOLD_W(HOLD_W)
    ) u_det_a (
        .clk(CLK),
        .arst_n(ARST_N),
        .enable(1'b1),
        .sample_mag(SAMPLE_A),
        .threshold(thresh_q),
        .hold_count(hold_q),
        .flag_q(fa)
    );

    // Channel B silent on the single variant
    ofc_ovr_det #(
        .SAMPLE_W(SAMPLE_W),
        .HOLD_W(HOLD_W)
    ) u_det_b (
        .clk(CLK),
        .arst_n(ARST_N),
        .enable(multi),
        .sample_mag(SAMPLE_B),
        .threshold(thresh_q),
        .hold_count(hold_q),
        .flag_q(fb)
    );

    // Channel C silent unless quad
    ofc_ovr_det #(
        .SAMPLE_W(SAMPLE_W),
        .HOLD_W(HOLD_W)
    ) u_det_c (
        .clk(CLK),
        .arst_n(ARST_N),
        .enable(quad),
        .sample_mag(SAMPLE_C),
        .threshold(thresh_q),
        .hold_count(hold_q),
        .flag_q(fc)
    );

    // Channel D silent unless quad
    ofc_ovr_det #(
        .SAMPLE_W(SAMPLE_W),
        .HOLD_W(HOLD_W)
    ) u_det_d (
        .clk(CLK),
        .arst_n(ARST_N),
        .enable(quad),
        .sample_mag(SAMPLE_D),
        .threshold(thresh_q),
        .hold_count(hold_q),
        .flag_q(fd)
    );

    // ****************************************************************
    // Output registers
    // ****************************************************************
    wire ref_pin_d;
    wire c_pin_d;
    wire d_pin_d;

    assign ref_pin_d = en_s_q && !pd_s_q && ref_s_q;
    assign c_pin_d = c_clk_mode ? pick_clk(sel_c, ref_s_q, div2, div4) : fc;
    assign d_pin_d = d_clk_mode ? pick_clk(ddiv, ref_s_q, div2, div4) : fd;

    // Every pin leaves from a flop; reference copies lag SYNTH_REF_CLK by 3 cycles, divided clocks by 4
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            OVR_FLAG_A <= 1'b0;
            OVR_FLAG_B <= 1'b0;
            OVR_FLAG_OR_CLK_C <= 1'b0;
            OVR_FLAG_OR_CLK_D <= 1'b0;
            SYNTH_REFERENCE_OUTPUT <= 1'b0;
        end else begin
            OVR_FLAG_A <= fa;
            OVR_FLAG_B <= fb;
            SYNTH_REFERENCE_OUTPUT <= ref_pin_d;
            OVR_FLAG_OR_CLK_C <= c_pin_d;
            OVR_FLAG_OR_CLK_D <= d_pin_d;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    wire [7:0] status;

    // Status bits; flags are internal, ahead of the pins by one cycle
    assign status[0] = fa;
    assign status[1] = fb;
    assign status[2] = fc;
    assign status[3] = fd;
    assign status[4] = en_s_q;
    assign status[5] = pd_s_q;
    assign status[6] = d_clk_mode;
    assign status[7] = c_clk_mode;

    // Unmapped addresses read zero
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `OFC_ADDR_THRESH: begin
                    REG_RDATA <= {{(32-SAMPLE_W){1'b0}}, thresh_q};
                end
                `OFC_ADDR_HOLD: begin
                    REG_RDATA <= {{(32-HOLD_W){1'b0}}, hold_q};
                end
                `OFC_ADDR_CLKCTL: begin
                    REG_RDATA <= {26'h0000000, clkctl_q};
                end
                `OFC_ADDR_STATUS: begin
                    REG_RDATA <= {24'h000000, status};
                end
                `OFC_ADDR_VARIANT: begin
                    REG_RDATA <= {30'h00000000, VARIANT};
                end
                default: begin
                    REG_RDATA <= 32'h00000000;
                end
            endcase
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

endmodule // ofc_top

/* logic/ofc_defs.vh */
`ifndef OFC_DEFS_VH
`define OFC_DEFS_VH

// ****************************************************************
// Register offsets (8-bit address, 32-bit data)
// ****************************************************************
`define OFC_ADDR_THRESH 8'h00
`define OFC_ADDR_HOLD 8'h04
`define OFC_ADDR_CLKCTL 8'h08
`define OFC_ADDR_STATUS 8'h0C
`define OFC_ADDR_VARIANT 8'h10

// ****************************************************************
// Field positions of the clock control register
// ****************************************************************
`define OFC_CLKCTL_OVR_EN 0
`define OFC_CLKCTL_SEL_LO 1
`define OFC_CLKCTL_SEL_HI 2
`define OFC_CLKCTL_DIS 3
`define OFC_CLKCTL_DDIV_LO 4
`define OFC_CLKCTL_DDIV_HI 5

// ****************************************************************
// Reset values
// ****************************************************************
`define OFC_RST_THRESH 12'hFFF
`define OFC_RST_HOLD 8'h01
`define OFC_RST_CLKCTL 6'h00

// ****************************************************************
// Clock select encodings
// ****************************************************************
`define OFC_SEL_FLAG 2'h0
`define OFC_SEL_DIV1 2'h1
`define OFC_SEL_DIV2 2'h2
`define OFC_SEL_DIV4 2'h3

// ****************************************************************
// Channel count variants
// ****************************************************************
`define OFC_VAR_SINGLE 2'h0
`define OFC_VAR_DUAL 2'h1
`define OFC_VAR_QUAD 2'h2

`endif

/* logic/ofc_ovr_det.v */
`timescale 1ns/1ps
`include "ofc_defs.vh"

module ofc_ovr_det #(
    parameter SAMPLE_W = 12,
    parameter HOLD_W = 8
) (
    input wire clk,
    input wire arst_n,
    input wire enable,
    input wire [SAMPLE_W-1:0] sample_mag,
    input wire [SAMPLE_W-1:0] threshold,
    input wire [HOLD_W-1:0] hold_count,
    output reg flag_q
);

    reg [HOLD_W-1:0] cnt_q;
    reg [HOLD_W-1:0] cnt_d;
    reg flag_d;
    wire over;

    assign over = enable && (sample_mag > threshold);

    // Flag set on exceed, high for hold_count+1 cycles after last exceed
    always @* begin
        flag_d = flag_q;
        cnt_d = cnt_q;
        if (over) begin
            flag_d = 1'b1;
            cnt_d = hold_count;
        end else if (cnt_q != {HOLD_W{1'b0}}) begin
            cnt_d = cnt_q - {{(HOLD_W-1){1'b0}}, 1'b1};
        end else begin
            flag_d = 1'b0;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 1'b0;
            cnt_q <= {HOLD_W{1'b0}};
        end else begin
            flag_q <= flag_d;
            cnt_q <= cnt_d;
        end
    end

endmodule // ofc_ovr_det

/* logic/ofc_clk_div.v */
`timescale 1ns/1ps
`include "ofc_defs.vh"

module ofc_clk_div (
    input wire clk,
    input wire arst_n,
    input wire run,
    input wire ref_clk,
    output reg div2_q,
    output reg div4_q
);

    reg ref_q;

    // Divider counts rising edges of the sampled reference clock;
    // a stop clears both outputs so they restart low
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_q <= 1'b0;
            div2_q <= 1'b0;
            div4_q <= 1'b0;
        end else begin
            ref_q <= ref_clk;
            if (!run) begin
                div2_q <= 1'b0;
                div4_q <= 1'b0;
            end else if (ref_clk && !ref_q) begin
                div2_q <= ~div2_q;
                if (div2_q) begin
                    div4_q <= ~div4_q;
                end
            end
        end
    end

endmodule // ofc_clk_div

/* verif/ofc_properties.sv */
`timescale 1ns/1ps
`include "ofc_defs.vh"
// ****
// Pin checker
// ****
module ofc_chk #(
    parameter SAMPLE_W = 12
) (
    input wire CLK,
    input wire ARST_N,
    input wire [SAMPLE_W-1:0] SAMPLE_A,
    input wire [SAMPLE_W-1:0] SAMPLE_B,
    input wire [SAMPLE_W-1:0] SAMPLE_C,
    input wire [SAMPLE_W-1:0] SAMPLE_D,
    input wire [1:0] CLKOUT_SELECT_PINS,
    input wire SYNTH_ENABLE_PIN,
    input wire POWERDOWN_PIN,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire OVR_FLAG_A,
    input wire OVR_FLAG_B,
    input wire OVR_FLAG_OR_CLK_C,
    input wire OVR_FLAG_OR_CLK_D,
    input wire SYNTH_REFERENCE_OUTPUT
);
    reg [SAMPLE_W-1:0] thr_q;
    reg [7:0] hold_q;
    reg ovr_q;
    reg [9:0] since_q;
    // Shadow of software limits; since_q saturates so idle stays low
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            thr_q <= `OFC_RST_THRESH;
            hold_q <= `OFC_RST_HOLD;
            ovr_q <= 1'b0;
            since_q <= 10'h3FF;
        end else begin
            if (REG_WR && REG_ADDR == `OFC_ADDR_THRESH)
                thr_q <= REG_WDATA[SAMPLE_W-1:0];
            if (REG_WR && REG_ADDR == `OFC_ADDR_HOLD)
                hold_q <= REG_WDATA[7:0];
            if (REG_WR && REG_ADDR == `OFC_ADDR_CLKCTL)
                ovr_q <= REG_WDATA[`OFC_CLKCTL_OVR_EN];
            if (SAMPLE_A > thr_q)
                since_q <= 10'h0;
            else if (since_q != 10'h3FF)
                since_q <= since_q + 10'h1;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    // Strap pins low long enough to pass the synchroniser
    sequence s_flag_mode;
        (CLKOUT_SELECT_PINS == `OFC_SEL_FLAG && !ovr_q) [*5];
    endsequence
    sequence s_hold_run;
        since_q >= {2'h0, hold_q} + 10'h2;
    endsequence
    AST_A_RISE: assert property (SAMPLE_A > thr_q |-> ##2 OVR_FLAG_A) else $error("A late");
    AST_B_RISE: assert property (SAMPLE_B > thr_q |-> ##2 OVR_FLAG_B) else $error("B late");
    AST_C_FLAG: assert property (s_flag_mode ##0 (SAMPLE_C > thr_q) |-> ##2 OVR_FLAG_OR_CLK_C) else $error("C");
    AST_D_FLAG: assert property (s_flag_mode ##0 (SAMPLE_D > thr_q) |-> ##2 OVR_FLAG_OR_CLK_D) else $error("D");
    AST_A_HOLD: assert property ($fell(OVR_FLAG_A) |-> s_hold_run) else $error("A short");
    AST_A_FALL: assert property (s_hold_run |-> !OVR_FLAG_A) else $error("A stuck");
    AST_PD_STOP: assert property (POWERDOWN_PIN [*6] |-> !SYNTH_REFERENCE_OUTPUT) else $error("ref in pd");
    AST_EN_GATE: assert property (!SYNTH_ENABLE_PIN [*6] |-> !SYNTH_REFERENCE_OUTPUT) else $error("ref no en");
endmodule // ofc_chk

bind ofc_top ofc_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.CLK(CLK), .ARST_N(ARST_N), .SAMPLE_A(SAMPLE_A),
    .SAMPLE_B(SAMPLE_B), .SAMPLE_C(SAMPLE_C), .SAMPLE_D(SAMPLE_D), .CLKOUT_SELECT_PINS(CLKOUT_SELECT_PINS),
    .SYNTH_ENABLE_PIN(SYNTH_ENABLE_PIN), .POWERDOWN_PIN(POWERDOWN_PIN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .OVR_FLAG_A(OVR_FLAG_A), .OVR_FLAG_B(OVR_FLAG_B),
    .OVR_FLAG_OR_CLK_C(OVR_FLAG_OR_CLK_C), .OVR_FLAG_OR_CLK_D(OVR_FLAG_OR_CLK_D),
    .SYNTH_REFERENCE_OUTPUT(SYNTH_REFERENCE_OUTPUT));

/* verif/ofc_sys_sink.sv */
`timescale 1ns/1ps
// ****
// System-side clock receiver
// ****
module ofc_sys_sink (
    input wire clk,
    input wire clr,
    input wire [2:0] pins,
    output reg [15:0] cnt_c,
    output reg [15:0] cnt_d,
    output reg [15:0] cnt_r
);
    reg [2:0] prev_q;
    // Rising edges seen in the core clock; needs clocks under a quarter rate
    always @(posedge clk) begin
        prev_q <= pins;
        cnt_c <= clr ? 16'h0 : cnt_c + {15'h0, pins[0] & ~prev_q[0]};
        cnt_d <= clr ? 16'h0 : cnt_d + {15'h0, pins[1] & ~prev_q[1]};
        cnt_r <= clr ? 16'h0 : cnt_r + {15'h0, pins[2] & ~prev_q[2]};
    end
endmodule // ofc_sys_sink

/* verif/tb_top.sv */
`timescale 1ns/1ps
`include "ofc_defs.vh"
// ****
// Bench
// ****
module tb_top;
    reg clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b1, pd = 1'b0, refc = 1'b0, clr = 1'b0;
    reg rd_d = 1'b0;
    reg [11:0] sa = 12'h0, sb = 12'h0, sc = 12'h0, sd = 12'h0;
    reg [1:0] sel = 2'h1;
    reg [2:0] rcnt = 3'h0;
    reg [7:0] addr = 8'h0;
    reg [31:0] wdata = 32'h0, seed = 32'h5FFA7407, rv;
    reg [31:0] expq[$];
    wire [31:0] rdata;
    wire fa, fb, fc, fd, fr;
    wire [15:0] nc, nd, nr;
    integer n_fail = 0, total_checks = 0, j, hold;
    ofc_top DUT (.CLK(clk), .ARST_N(arst_n), .SAMPLE_A(sa), .SAMPLE_B(sb), .SAMPLE_C(sc), .SAMPLE_D(sd),
        .SYNTH_REF_CLK(refc), .CLKOUT_SELECT_PINS(sel), .SYNTH_ENABLE_PIN(en), .POWERDOWN_PIN(pd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .OVR_FLAG_A(fa),
        .OVR_FLAG_B(fb), .OVR_FLAG_OR_CLK_C(fc), .OVR_FLAG_OR_CLK_D(fd), .SYNTH_REFERENCE_OUTPUT(fr));
    ofc_sys_sink u_sink (.clk(clk), .clr(clr), .pins({fr, fd, fc}), .cnt_c(nc), .cnt_d(nd), .cnt_r(nr));
    initial forever #2.5 clk = ~clk;
    // Reference at an eighth of the core rate, safely under a quarter
    always @(posedge clk) begin
        rcnt <= rcnt + 3'h1;
        refc <= rcnt[2];
    end
    task check(input [31:0] seen, input [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // One-cycle strobe; a read leaves its expected word in the queue
    task acc(input w, input [7:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        if (!w) expq.push_back(d);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // Read word stands only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) check(rdata, expq.pop_front());
        else if (arst_n) check(rdata, 32'h0);
    end
    // Edge counts over 160 cycles, one edge of phase slack
    task clocks(input [1:0] s, input p, input e, input [15:0] ec, input [15:0] ed, input [15:0] er);
        @(posedge clk);
        sel <= s;
        pd <= p;
        en <= e;
        repeat (12) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (160) @(posedge clk);
        #1;
        check(nc + 16'h1 >= ec && nc <= ec + 16'h1, 1);
        check(nd + 16'h1 >= ed && nd <= ed + 16'h1, 1);
        check(nr + 16'h1 >= er && nr <= er + 16'h1, 1);
    endtask
    function [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        xs = seed;
    endfunction
    task end_sim;
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        #100000;
        n_fail = n_fail + 1;
        end_sim;
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        clocks(2'h1, 1'b0, 1'b1, 16'h14, 16'h14, 16'h14);
        acc(1'b0, `OFC_ADDR_STATUS, 32'hD0);
        acc(1'b0, `OFC_ADDR_VARIANT, {30'h0, `OFC_VAR_QUAD});
        acc(1'b0, `OFC_ADDR_THRESH, 32'hFFF);
        acc(1'b0, `OFC_ADDR_HOLD, 32'h1);
        acc(1'b0, `OFC_ADDR_CLKCTL, 32'h0);
        acc(1'b0, 8'h14, 32'h0);
        clocks(2'h2, 1'b0, 1'b1, 16'hA, 16'h14, 16'h14);
        clocks(2'h3, 1'b0, 1'b1, 16'h5, 16'h14, 16'h14);
        acc(1'b1, `OFC_ADDR_CLKCTL, 32'h33);
        clocks(2'h0, 1'b0, 1'b1, 16'h14, 16'h5, 16'h14);
        acc(1'b1, `OFC_ADDR_CLKCTL, 32'h8);
        clocks(2'h3, 1'b0, 1'b1, 16'h0, 16'h0, 16'h14);
        acc(1'b1, `OFC_ADDR_CLKCTL, 32'h0);
        clocks(2'h1, 1'b1, 1'b1, 16'h0, 16'h0, 16'h0);
        acc(1'b0, `OFC_ADDR_STATUS, 32'h30);
        clocks(2'h1, 1'b0, 1'b0, 16'h0, 16'h0, 16'h0);
        clocks(2'h0, 1'b0, 1'b1, 16'h0, 16'h0, 16'h14);
        hold = xs() % 8 + 1;
        acc(1'b1, `OFC_ADDR_HOLD, hold);
        acc(1'b1, `OFC_ADDR_THRESH, 32'h100);
        acc(1'b0, `OFC_ADDR_HOLD, hold);
        {sa, sb, sc, sd} <= {4{12'h101}};
        // Single exceed then exactly at threshold, which is not over
        for (j = 1; j < 14; j = j + 1) begin
            @(posedge clk);
            {sa, sb, sc, sd} <= {4{12'h100}};
            #1;
            check({fa, fb, fc, fd}, (j >= 2 && j <= hold + 2) ? 4'hF : 4'h0);
        end
        // Random samples; the checker judges every cycle
        repeat (300) begin
            @(posedge clk);
            rv = xs();
            {sa, sb} <= rv[23:0];
            {sc, sd} <= {rv[11:0], rv[31:20]};
        end
        end_sim;
    end
endmodule // tb_top
